// ===== rtl/egac_gear_ctrl.sv
// What this block does
// - start commands whose inputs nobody drives first
// - circular gear feeding between commands not yet started raises ratio overflow error
// - stop mode repeat: cancel is never honoured
// - pass or in-position-off mode: cancel ends gearing
// - manual mode pauses gearing except in a deceleration stop, stops without deceleration
// - pause stops at once except in a deceleration stop; resume if not moved
// - forced end stops, clears all, restarts block
// - servo unlock stops; no continuation allowed
// - axis operating high while gearing executes
// - positioning completed low while gearing executes
// - error counter reset stops all axis tasks
// - error counter reset release restarts prereading
// - deceleration stop drains error counter, then halts
`timescale 1ns/1ps
`default_nettype none
`include "egac_defs.svh"

module egac_gear_ctrl (
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire logic                          ce,
    input  wire logic                          autoMode,
    input  wire logic                          pauseBit,
    input  wire logic                          forcedEndBit,
    input  wire logic                          servoUnlockBit,
    input  wire logic                          errCntReset,
    input  wire logic                          decelStop,
    input  wire logic                          cmdLoad,
    input  wire logic [`EGAC_SLOT_W-1:0]       cmdSlot,
    input  wire logic [`EGAC_AXIS_W-1:0]       cmdInAxis,
    input  wire logic [`EGAC_AXIS_W-1:0]       cmdIntAxis,
    input  wire logic [`EGAC_AXIS_W-1:0]       cmdDrvAxis,
    input  wire logic [`EGAC_MODE_W-1:0]       cmdMode,
    input  wire logic                          cmdRepeat,
    input  wire logic                          cancelReq,
    input  wire logic [`EGAC_SLOT_W-1:0]       cancelSlot,
    input  wire logic                          drivenMoved,
    input  wire logic                          inputPulse,
    input  wire logic [`EGAC_ERRCNT_W-1:0]     followErr,
    output logic                               axisOperating,
    output logic                               posCompleted,
    output logic                               drivenPulse,
    output logic                               ratioOverflowErr,
    output logic [`EGAC_SLOTS-1:0]             slotActive,
    output logic [`EGAC_SLOTS-1:0]             slotPending,
    output logic                               startStrobe,
    output logic [`EGAC_SLOT_W-1:0]            startSlot,
    output logic                               cancelDone,
    output logic                               cancelIgnored,
    output logic                               resumeRefused,
    output logic                               prereadRun,
    output logic                               prereadRestart,
    output logic                               blockRestart
);
    localparam int NS = `EGAC_SLOTS;

    // true when a command driving drv feeds the one reading in or integ
    function automatic logic feeds(input logic [`EGAC_AXIS_W-1:0] inAx,
                                   input logic [`EGAC_AXIS_W-1:0] intAx,
                                   input logic [`EGAC_AXIS_W-1:0] drv);
        feeds = (drv != `EGAC_AXIS_NONE) && ((inAx == drv) || (intAx == drv));
    endfunction

    function automatic logic [`EGAC_SLOT_W-1:0] lowestSet(input logic [NS-1:0] v);
        lowestSet = `EGAC_SLOT_ZERO;
        for (int k = NS - 1; k >= 0; k--) begin
            if (v[k]) begin
                lowestSet = k[`EGAC_SLOT_W-1:0];
            end
        end
    endfunction

    function automatic logic cancellable(input logic [`EGAC_MODE_W-1:0] m);
        cancellable = (m == `EGAC_MODE_PASS) || (m == `EGAC_MODE_INPOSOFF);
    endfunction

    logic [`EGAC_AXIS_W-1:0]   inAx_q   [0:NS-1];
    logic [`EGAC_AXIS_W-1:0]   intAx_q  [0:NS-1];
    logic [`EGAC_AXIS_W-1:0]   drvAx_q  [0:NS-1];
    logic [`EGAC_MODE_W-1:0]   mode_q   [0:NS-1];
    logic [NS-1:0]             repeat_q;
    logic [NS-1:0]             pending_q;
    logic [NS-1:0]             active_q;
    egac_pkg::egac_state_t     state_q;
    logic                      moved_q;
    logic                      errRst_q;
    logic                      forced_q;
    logic [`EGAC_ERRCNT_W-1:0] drain_q;
    logic                      pulse_q;
    logic                      ovf_q;
    logic                      start_q;
    logic [`EGAC_SLOT_W-1:0]   startIdx_q;
    logic                      cDone_q;
    logic                      cIgn_q;
    logic                      refused_q;
    logic                      preRst_q;
    logic                      blkRst_q;

    logic [NS-1:0]             blocked;
    logic [NS-1:0]             ready;
    logic [NS-1:0]             slotBit;
    logic                      holdReq;
    logic                      canStart;
    logic                      deadlock;
    logic                      doStart;
    logic [`EGAC_SLOT_W-1:0]   startPick;
    logic                      cancelHit;
    logic                      cancelOk;
    logic                      executing;
    logic                      stopAll;

    genvar gi, gj;
    generate
        for (gi = 0; gi < NS; gi++) begin : gDep
            logic [NS-1:0] dep;
            for (gj = 0; gj < NS; gj++) begin : gCol
                // only commands not yet started can still hold another back
                if (gi == gj) begin : gSelf
                    assign dep[gj] = 1'b0;
                end else begin : gOther
                    assign dep[gj] = pending_q[gj] &&
                                     feeds(inAx_q[gi], intAx_q[gi], drvAx_q[gj]);
                end
            end
            assign blocked[gi] = |dep;
        end
    endgenerate

    assign ready     = pending_q & ~blocked;
    assign startPick = lowestSet(ready);
    assign holdReq   = pauseBit || !autoMode;
    assign stopAll   = errCntReset || servoUnlockBit || forcedEndBit;
    // a burst of back-to-back loads is resolved as one group, so load order cannot win
    assign canStart  = !stopAll && !holdReq && !cmdLoad &&
                       (state_q == egac_pkg::ST_IDLE || state_q == egac_pkg::ST_RUN);
    assign deadlock  = (pending_q != `EGAC_MASK_ZERO) && (ready == `EGAC_MASK_ZERO);
    assign doStart   = canStart && !deadlock && (ready != `EGAC_MASK_ZERO);
    assign slotBit   = NS'(1) << cancelSlot;
    assign cancelHit = cancelReq && active_q[cancelSlot];
    // stop mode never terminates, so its cancel block is never reached
    assign cancelOk  = cancelHit && cancellable(mode_q[cancelSlot]);
    assign executing = (state_q != egac_pkg::ST_IDLE) && (active_q != `EGAC_MASK_ZERO);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int k = 0; k < NS; k++) begin
                inAx_q[k]  <= `EGAC_AXIS_NONE;
                intAx_q[k] <= `EGAC_AXIS_NONE;
                drvAx_q[k] <= `EGAC_AXIS_NONE;
                mode_q[k]  <= `EGAC_MODE_STOP;
            end
            repeat_q <= `EGAC_MASK_ZERO;
        end else if (ce && cmdLoad) begin
            inAx_q[cmdSlot]   <= cmdInAxis;
            intAx_q[cmdSlot]  <= cmdIntAxis;
            drvAx_q[cmdSlot]  <= cmdDrvAxis;
            mode_q[cmdSlot]   <= cmdMode;
            repeat_q[cmdSlot] <= cmdRepeat;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q    <= egac_pkg::ST_IDLE;
            pending_q  <= `EGAC_MASK_ZERO;
            active_q   <= `EGAC_MASK_ZERO;
            moved_q    <= 1'b0;
            errRst_q   <= 1'b0;
            forced_q   <= 1'b0;
            drain_q    <= `EGAC_ERRCNT_ZERO;
            pulse_q    <= 1'b0;
            ovf_q      <= 1'b0;
            start_q    <= 1'b0;
            startIdx_q <= `EGAC_SLOT_ZERO;
            cDone_q    <= 1'b0;
            cIgn_q     <= 1'b0;
            refused_q  <= 1'b0;
            preRst_q   <= 1'b0;
            blkRst_q   <= 1'b0;
        end else if (ce) begin
            errRst_q  <= errCntReset;
            forced_q  <= forcedEndBit;
            pulse_q   <= 1'b0;
            ovf_q     <= 1'b0;
            start_q   <= 1'b0;
            cDone_q   <= 1'b0;
            cIgn_q    <= 1'b0;
            refused_q <= 1'b0;
            preRst_q  <= errRst_q && !errCntReset;
            blkRst_q  <= forced_q && !forcedEndBit;
            if (cmdLoad) begin
                pending_q[cmdSlot] <= 1'b1;
            end
            if (stopAll) begin
                // immediate halt with no deceleration; nothing is resumable
                state_q   <= egac_pkg::ST_IDLE;
                active_q  <= `EGAC_MASK_ZERO;
                pending_q <= `EGAC_MASK_ZERO;
                drain_q   <= `EGAC_ERRCNT_ZERO;
            end else begin
                if (deadlock && canStart) begin
                    ovf_q     <= 1'b1;
                    pending_q <= `EGAC_MASK_ZERO;
                end
                if (doStart) begin
                    pending_q[startPick] <= 1'b0;
                    active_q[startPick]  <= 1'b1;
                    start_q              <= 1'b1;
                    startIdx_q           <= startPick;
                end
                if (cancelOk) begin
                    active_q <= (active_q & ~slotBit) |
                                (doStart ? (NS'(1) << startPick) : `EGAC_MASK_ZERO);
                    cDone_q  <= 1'b1;
                end else if (cancelReq) begin
                    cIgn_q <= 1'b1;
                end
                case (state_q)
                    egac_pkg::ST_IDLE: begin
                        if (doStart) begin
                            state_q <= egac_pkg::ST_RUN;
                        end
                    end
                    egac_pkg::ST_RUN: begin
                        if (holdReq) begin
                            state_q <= egac_pkg::ST_PAUSE;
                            moved_q <= 1'b0;
                        end else if (decelStop) begin
                            state_q <= egac_pkg::ST_DECEL;
                            drain_q <= followErr;
                        end else begin
                            pulse_q <= inputPulse && (active_q != `EGAC_MASK_ZERO);
                            if (active_q == `EGAC_MASK_ZERO && !doStart) begin
                                state_q <= egac_pkg::ST_IDLE;
                            end
                        end
                    end
                    egac_pkg::ST_PAUSE: begin
                        if (drivenMoved) begin
                            moved_q <= 1'b1;
                        end
                        if (!holdReq) begin
                            // a moved axis has lost its gear phase, so drop it
                            if (moved_q || drivenMoved) begin
                                refused_q <= 1'b1;
                                active_q  <= `EGAC_MASK_ZERO;
                                state_q   <= egac_pkg::ST_IDLE;
                            end else begin
                                state_q <= egac_pkg::ST_RUN;
                            end
                        end
                    end
                    egac_pkg::ST_DECEL: begin
                        if (drain_q != `EGAC_ERRCNT_ZERO) begin
                            pulse_q <= 1'b1;
                            drain_q <= drain_q - `EGAC_ERRCNT_ONE;
                        end else begin
                            active_q <= `EGAC_MASK_ZERO;
                            state_q  <= egac_pkg::ST_IDLE;
                        end
                    end
                    default: begin
                        state_q <= egac_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end

    assign axisOperating    = executing;
    assign posCompleted     = !executing && (active_q == `EGAC_MASK_ZERO);
    assign prereadRun       = !errCntReset;
    assign drivenPulse      = pulse_q;
    assign ratioOverflowErr = ovf_q;
    assign slotActive       = active_q;
    assign slotPending      = pending_q;
    assign startStrobe      = start_q;
    assign startSlot        = startIdx_q;
    assign cancelDone       = cDone_q;
    assign cancelIgnored    = cIgn_q;
    assign resumeRefused    = refused_q;
    assign prereadRestart   = preRst_q;
    assign blockRestart     = blkRst_q;
endmodule

`default_nettype wire

// ===== rtl/egac_defs.svh
`ifndef EGAC_DEFS_SVH
`define EGAC_DEFS_SVH

`define EGAC_SLOTS        4
`define EGAC_SLOT_W       2
`define EGAC_AXIS_W       3
`define EGAC_AXIS_NONE    3'h0
`define EGAC_MODE_W       2
`define EGAC_MODE_STOP    2'h0
`define EGAC_MODE_PASS    2'h1
`define EGAC_MODE_INPOSOFF 2'h2
`define EGAC_ERRCNT_W     16
`define EGAC_ERRCNT_ZERO  16'h0000
`define EGAC_ERRCNT_ONE   16'h0001
`define EGAC_MASK_ZERO    4'h0
`define EGAC_SLOT_ZERO    2'h0

`endif

// ===== rtl/egac_pkg.sv
package egac_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN,
        ST_PAUSE,
        ST_DECEL
    } egac_state_t;
endpackage

// ===== verif/egac_gear_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "egac_defs.svh"
module egac_gear_props (
    input wire logic                   clk,
    input wire logic                   rst,
    input wire logic                   ce,
    input wire logic                   autoMode,
    input wire logic                   pauseBit,
    input wire logic                   forcedEndBit,
    input wire logic                   servoUnlockBit,
    input wire logic                   errCntReset,
    input wire logic                   cancelReq,
    input wire logic                   axisOperating,
    input wire logic                   posCompleted,
    input wire logic                   drivenPulse,
    input wire logic                   ratioOverflowErr,
    input wire logic [`EGAC_SLOTS-1:0] slotActive,
    input wire logic [`EGAC_SLOTS-1:0] slotPending,
    input wire logic                   cancelDone,
    input wire logic                   cancelIgnored
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_gear_operating: assert property (|slotActive |-> axisOperating)
        else $error("axis operating low while gearing");
    a_poscomp_low: assert property (|slotActive |-> !posCompleted)
        else $error("positioning completed high while gearing");
    a_overflow_clears: assert property (
        ratioOverflowErr |-> slotPending == `EGAC_MASK_ZERO)
        else $error("pending commands kept after overflow");
    a_cancel_answer: assert property (
        ce && cancelReq |=> cancelDone ^ cancelIgnored)
        else $error("cancel without single answer");
    a_pause_halt: assert property (ce && pauseBit && |slotActive |=> !drivenPulse)
        else $error("pulse while paused");
    a_manual_halt: assert property (ce && !autoMode && |slotActive |=> !drivenPulse)
        else $error("pulse in manual mode");
    a_forced_clear: assert property (
        ce && forcedEndBit |=> slotActive == `EGAC_MASK_ZERO && slotPending == `EGAC_MASK_ZERO)
        else $error("work kept after forced end");
    a_unlock_halt: assert property (
        ce && servoUnlockBit |=> slotActive == `EGAC_MASK_ZERO && !drivenPulse)
        else $error("gearing kept after unlock");
    a_errcnt_stop: assert property (
        ce && errCntReset |=> slotActive == `EGAC_MASK_ZERO)
        else $error("gearing kept in error counter reset");
endmodule
bind egac_gear_ctrl egac_gear_props egac_gear_props_inst (.clk(clk), .rst(rst), .ce(ce),
    .autoMode(autoMode), .pauseBit(pauseBit), .forcedEndBit(forcedEndBit),
    .servoUnlockBit(servoUnlockBit), .errCntReset(errCntReset), .cancelReq(cancelReq),
    .axisOperating(axisOperating), .posCompleted(posCompleted), .drivenPulse(drivenPulse),
    .ratioOverflowErr(ratioOverflowErr), .slotActive(slotActive), .slotPending(slotPending),
    .cancelDone(cancelDone), .cancelIgnored(cancelIgnored));
`default_nettype wire

// ===== verif/egac_host.sv
`timescale 1ns/1ps
`default_nettype none
module egac_host (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic [5:0] req,
    input wire logic       axisOperating,
    output logic           autoMode,
    output logic           pauseBit,
    output logic           forcedEndBit,
    output logic           servoUnlockBit,
    output logic           decelStop,
    output logic           errCntReset
);
    logic [5:0] ctl_q;
    // forced end, servo unlock and decel stop bits stay up until the axis shows it has stopped; pause and error counter reset do not
    wire logic [5:0] holdMask = {1'h0, {3{axisOperating}}, 2'h0};
    always_ff @(posedge clk or posedge rst) begin
        if (rst) ctl_q <= 6'h00;
        else ctl_q <= req | (ctl_q & holdMask);
    end
    assign autoMode = !ctl_q[0];
    assign pauseBit = ctl_q[1];
    assign forcedEndBit = ctl_q[2];
    assign servoUnlockBit = ctl_q[3];
    assign decelStop = ctl_q[4];
    assign errCntReset = ctl_q[5];
endmodule
`default_nettype wire

// ===== verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 0, rst = 1, ce = 1, cmdLoad = 0, cmdRepeat = 0, cancelReq = 0;
    logic drivenMoved = 0, inputPulse = 0;
    logic [1:0] cmdSlot = 0, cmdMode = 0, cancelSlot = 0, startSlot;
    logic [2:0] cmdInAxis = 0, cmdIntAxis = 0, cmdDrvAxis = 0;
    logic [5:0] req = 0;
    logic [15:0] followErr = 0;
    logic [3:0] slotActive, slotPending;
    logic autoMode, pauseBit, forcedEndBit, servoUnlockBit, decelStop, errCntReset;
    logic axisOperating, posCompleted, drivenPulse, ratioOverflowErr, startStrobe;
    logic cancelDone, cancelIgnored, resumeRefused, prereadRun, prereadRestart, blockRestart;
    int n_errors = 0, checked = 0;
    always #25 clk = ~clk;
    egac_host egac_host_inst (.clk(clk), .rst(rst), .req(req), .axisOperating(axisOperating),
        .autoMode(autoMode), .pauseBit(pauseBit), .forcedEndBit(forcedEndBit),
        .servoUnlockBit(servoUnlockBit), .decelStop(decelStop), .errCntReset(errCntReset));
    egac_gear_ctrl egac_gear_ctrl_inst (.clk(clk), .rst(rst), .ce(ce), .autoMode(autoMode),
        .pauseBit(pauseBit), .forcedEndBit(forcedEndBit), .servoUnlockBit(servoUnlockBit),
        .errCntReset(errCntReset), .decelStop(decelStop), .cmdLoad(cmdLoad), .cmdSlot(cmdSlot),
        .cmdInAxis(cmdInAxis), .cmdIntAxis(cmdIntAxis), .cmdDrvAxis(cmdDrvAxis),
        .cmdMode(cmdMode), .cmdRepeat(cmdRepeat), .cancelReq(cancelReq), .cancelSlot(cancelSlot),
        .drivenMoved(drivenMoved), .inputPulse(inputPulse), .followErr(followErr),
        .axisOperating(axisOperating), .posCompleted(posCompleted), .drivenPulse(drivenPulse),
        .ratioOverflowErr(ratioOverflowErr), .slotActive(slotActive), .slotPending(slotPending),
        .startStrobe(startStrobe), .startSlot(startSlot), .cancelDone(cancelDone),
        .cancelIgnored(cancelIgnored), .resumeRefused(resumeRefused), .prereadRun(prereadRun),
        .prereadRestart(prereadRestart), .blockRestart(blockRestart));
    task tick;
        @(posedge clk);
        #1;
    endtask
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic waitHi(input string nm, ref logic f);
        for (int k = 0; k < 10 && f !== 1'h1; k++) begin
            tick;
        end
        chk(nm, 16'h0001, f);
    endtask
    // leaves cmdLoad high so loads may follow back to back
    task load(input logic [1:0] s, input logic [2:0] ia, ib, da, input logic [1:0] m,
              input logic r);
        cmdLoad = 1;
        cmdSlot = s;
        cmdInAxis = ia;
        cmdIntAxis = ib;
        cmdDrvAxis = da;
        cmdMode = m;
        cmdRepeat = r;
        tick;
    endtask
    task gear(input logic [1:0] s, input logic [1:0] m, input logic r);
        load(s, 3'h1, 3'h0, 3'h4, m, r);
        cmdLoad = 0;
        waitHi("startStrobe", startStrobe);
    endtask
    task cancel(input logic [1:0] s, input logic d);
        cancelReq = 1;
        cancelSlot = s;
        tick;
        cancelReq = 0;
        chk("cancelDone", d, cancelDone);
        chk("cancelIgnored", !d, cancelIgnored);
        tick;
    endtask
    task pulseIn(input logic e);
        inputPulse = 1;
        tick;
        inputPulse = 0;
        chk("drivenPulse", e, drivenPulse);
        tick;
    endtask
    task ctl(input logic [5:0] r, input int n);
        req = r;
        repeat (n) tick;
    endtask
    task t_loop;
        load(2'h0, 3'h0, 3'h2, 3'h1, 2'h1, 0);
        load(2'h1, 3'h1, 3'h0, 3'h2, 2'h1, 0);
        cmdLoad = 0;
        waitHi("ratioOverflowErr", ratioOverflowErr);
        tick;
        chk("slotPending", 16'h0000, slotPending);
        chk("slotActive", 16'h0000, slotActive);
    endtask
    task t_order;
        load(2'h0, 3'h2, 3'h0, 3'h3, 2'h1, 0);
        load(2'h1, 3'h1, 3'h0, 3'h2, 2'h2, 0);
        cmdLoad = 0;
        waitHi("startStrobe", startStrobe);
        chk("startSlot", 16'h0001, startSlot);
        tick;
        chk("startStrobe", 16'h0001, startStrobe);
        chk("startSlot", 16'h0000, startSlot);
        repeat (3) tick;
        chk("axisOperating", 16'h0001, axisOperating);
        chk("posCompleted", 16'h0000, posCompleted);
        pulseIn(1);
    endtask
    task t_cancel;
        cancel(2'h1, 1);
        cancel(2'h0, 1);
        chk("axisOperating", 16'h0000, axisOperating);
        chk("posCompleted", 16'h0001, posCompleted);
        cancel(2'h3, 0);
        gear(2'h2, 2'h0, 1);
        cancel(2'h2, 0);
        chk("slotActive", 16'h0004, slotActive);
        chk("axisOperating", 16'h0001, axisOperating);
    endtask
    task t_forced;
        ctl(6'h04, 3);
        chk("slotActive", 16'h0000, slotActive);
        req = 0;
        waitHi("blockRestart", blockRestart);
    endtask
    task t_pause;
        gear(2'h0, 2'h1, 0);
        ctl(6'h02, 2);
        pulseIn(0);
        chk("axisOperating", 16'h0001, axisOperating);
        ctl(6'h00, 3);
        pulseIn(1);
        ctl(6'h01, 2);
        drivenMoved = 1;
        tick;
        drivenMoved = 0;
        pulseIn(0);
        req = 0;
        waitHi("resumeRefused", resumeRefused);
        tick;
        chk("slotActive", 16'h0000, slotActive);
    endtask
    task t_unlock;
        gear(2'h1, 2'h1, 0);
        ctl(6'h08, 3);
        chk("slotActive", 16'h0000, slotActive);
        ctl(6'h00, 4);
        pulseIn(0);
        chk("axisOperating", 16'h0000, axisOperating);
    endtask
    task t_err;
        gear(2'h3, 2'h2, 0);
        ctl(6'h20, 2);
        chk("slotActive", 16'h0000, slotActive);
        chk("prereadRun", 16'h0000, prereadRun);
        req = 0;
        waitHi("prereadRestart", prereadRestart);
        chk("prereadRun", 16'h0001, prereadRun);
    endtask
    task t_decel;
        int n;
        n = 0;
        followErr = 16'h0003;
        gear(2'h0, 2'h1, 0);
        tick;
        req = 6'h10;
        repeat (12) begin
            tick;
            n += drivenPulse;
        end
        chk("pulseCount", 16'h0003, n[15:0]);
        chk("axisOperating", 16'h0000, axisOperating);
        ctl(6'h00, 2);
    endtask
    task results;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        #1 rst = 0;
        tick;
        t_loop;
        t_order;
        t_cancel;
        t_forced;
        t_pause;
        t_unlock;
        t_err;
        t_decel;
        results;
    end
    initial begin
        #(3000 * 50);
        n_errors++;
        results;
    end
endmodule
`default_nettype wire
